// >>> logic/radio_seq_pkg.sv
// Shared constants, types and register map of the radio sequencer
package radio_seq_pkg;

  localparam int unsigned CLK_KHZ       = 50000;
  localparam int unsigned REF_KHZ       = 44000;
  localparam int unsigned SYNTH_STEP_KHZ = 500;

  localparam int unsigned RX_SETTLE_NS  = 5000;
  localparam int unsigned POST_NOTCH_NS = 5000;
  localparam int unsigned SEARCH_MAX_NS = 8000;
  localparam int unsigned TX_RAMP_NS    = 2000;
  localparam int unsigned CAL_WAIT_NS   = 1000;

  // Counts are in reference ticks; least times round up, longest down
  localparam int unsigned RX_SETTLE_TK  =
    (RX_SETTLE_NS * REF_KHZ + 999999) / 1000000;
  localparam int unsigned POST_NOTCH_TK =
    (POST_NOTCH_NS * REF_KHZ + 999999) / 1000000;
  localparam int unsigned SEARCH_MAX_TK = SEARCH_MAX_NS * REF_KHZ / 1000000;
  localparam int unsigned TX_RAMP_TK    =
    (TX_RAMP_NS * REF_KHZ + 999999) / 1000000;
  localparam int unsigned CAL_WAIT_TK   =
    (CAL_WAIT_NS * REF_KHZ + 999999) / 1000000;
  localparam int unsigned TK_W          = 10;

  localparam logic [7:0] ADR_CTRL  = 8'h00;
  localparam logic [7:0] ADR_MAXG  = 8'h04;
  localparam logic [7:0] ADR_WAIT  = 8'h08;
  localparam logic [7:0] ADR_TXCFG = 8'h0C;
  localparam logic [7:0] ADR_SYNTH = 8'h10;
  localparam logic [7:0] ADR_STAT  = 8'h14;
  localparam logic [7:0] ADR_CAL   = 8'h18;

  localparam int unsigned CTRL_CYC_LSB = 0;
  localparam int unsigned CTRL_DIV_EN  = 2;
  localparam int unsigned CTRL_CAL_GO  = 3;
  localparam int unsigned CTRL_RESTART = 4;

  localparam int unsigned ST_NOTCH_LSB = 0;
  localparam int unsigned ST_AGC_LSB   = 2;
  localparam int unsigned ST_TX_LSB    = 5;
  localparam int unsigned ST_CAL_LSB   = 7;
  localparam int unsigned ST_GAIN_LSB  = 9;

  localparam logic [7:0]  CTRL_RST  = 8'h00;
  localparam logic [6:0]  MAXG_RST  = 7'h5A;
  localparam logic [23:0] WAIT_RST  = 24'h161616;
  localparam logic [3:0]  TXG_RST   = 4'hF;
  localparam logic [7:0]  TXDLY_RST = 8'h2C;
  localparam logic [7:0]  SYNTH_RST = 8'h00;

  localparam logic [6:0] RX_GAIN_MAX_DB = 7'h5A;
  localparam logic [6:0] LNA_DB         = 7'h1E;
  localparam logic [6:0] FILT_STEP_DB   = 7'h0F;
  localparam logic [6:0] LNA_ON_DB      = 7'h3C;

  typedef enum logic [1:0] {
    NOTCH_10M  = 2'b00,
    NOTCH_1M   = 2'b01,
    NOTCH_100K = 2'b10,
    NOTCH_10K  = 2'b11
  } notch_t;

  typedef enum logic [2:0] {
    AGC_IDLE   = 3'b000,
    AGC_SETTLE = 3'b001,
    AGC_DECIDE = 3'b010,
    AGC_WAIT   = 3'b011,
    AGC_POST   = 3'b100,
    AGC_HOLD   = 3'b101
  } agc_state_t;

  typedef enum logic [1:0] {
    TX_IDLE  = 2'b00,
    TX_DELAY = 2'b01,
    TX_RAMP  = 2'b10,
    TX_ON    = 2'b11
  } tx_state_t;

  typedef enum logic [1:0] {
    CAL_IDLE = 2'b00,
    CAL_MEAS = 2'b01,
    CAL_DONE = 2'b10
  } cal_state_t;

  typedef struct packed {
    logic       lna;
    logic [1:0] filt;
    logic [4:0] bb;
  } rx_gain_t;

  typedef struct packed {
    logic       upconv;
    logic [2:0] filt;
  } tx_gain_t;

endpackage

// >>> logic/ref_tick_gen.sv
// Fractional divider giving one enable pulse per reference clock period
`timescale 1ns/1ps
module ref_tick_gen (
  input  wire logic clk_i,
  input  wire logic rst_i,
  output logic      tick_o
);
  import radio_seq_pkg::*;

  localparam logic [16:0] INC = 17'(REF_KHZ);
  localparam logic [16:0] MOD = 17'(CLK_KHZ);

  logic [16:0] acc_q;
  logic [16:0] sum;

  // Ticks are spread with one-cycle jitter; average rate is exact
  assign sum = acc_q + INC;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc_q  <= 17'h00000;
      tick_o <= 1'b0;
    end else if (sum >= MOD) begin
      acc_q  <= sum - MOD;
      tick_o <= 1'b1;
    end else begin
      acc_q  <= sum;
      tick_o <= 1'b0;
    end
  end

endmodule

// >>> logic/radio_seq.sv
// Receive gain, DC-notch, transmit ramp and leakage calibration sequencer
//
// The implementer's own choices: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
// Functional notes
// - Synthesizer code moves the oscillator by 0.5 MHz per step.
// - Four notch corners: 10 MHz, 1 MHz, 100 kHz, 10 kHz.
// - During gain settling the notch alternates between 10 MHz and 1 MHz.
// - After settling: 100 kHz for 5 us, then 10 kHz.
// - Settling may span several diversity cycles; post after the last.
// - 10 kHz corner held until a burst, restart or receive entry starts a new gain cycle.
// - Entering receive loads the programmable maximum gain.
// - Receive entry gives 5 us settling at the 1 MHz notch.
// - Notch stays 1 MHz while gain remains at its initial maximum.
// - Gain search lowers gain stepwise until output reaches target.
// - Search ends at the latest at the first decision 8 us or more after starting.
// - Each gain switch is followed by a programmable wait period.
// - Gain split into two-step LNA, three-step filter, baseband; 90 dB.
// - Gain decisions use a log-envelope error against nominal level.
// - Transmit data bits are sampled on the 44 MHz reference tick.
// - Calibration reads LO leakage and drives I/Q compensation values.
// - Transmit ramp starts after programmable delay; ramp length fixed.
// - Transmit gain spans 15 dB in 1 dB steps.
// - Transmit gain is 0-7 dB filter plus one 8 dB upconverter step.
module radio_seq (
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire logic                     wb_cyc_i,
  input  wire logic                     wb_stb_i,
  input  wire logic                     wb_we_i,
  input  wire logic [7:0]               wb_adr_i,
  input  wire logic [31:0]              wb_dat_i,
  input  wire logic [3:0]               wb_sel_i,
  output logic      [31:0]              wb_dat_o,
  output logic                          wb_ack_o,
  input  wire logic                     rx_mode_i,
  input  wire logic                     tx_mode_i,
  input  wire logic                     burst_start_i,
  input  wire logic signed [7:0]        rssi_err_i,
  input  wire logic [7:0]               lo_leak_i,
  input  wire logic                     tx_i_bit_i,
  input  wire logic                     tx_q_bit_i,
  output radio_seq_pkg::notch_t         notch_sel_o,
  output radio_seq_pkg::rx_gain_t       rx_gain_o,
  output logic                          agc_done_o,
  output logic      [7:0]               synth_code_o,
  output radio_seq_pkg::tx_gain_t       tx_gain_o,
  output logic                          tx_ramp_o,
  output logic                          tx_on_o,
  output logic                          fir_i_o,
  output logic                          fir_q_o,
  output logic signed [7:0]             cal_i_o,
  output logic signed [7:0]             cal_q_o
);
  import radio_seq_pkg::*;

  localparam logic [TK_W-1:0] SETTLE_C = TK_W'(RX_SETTLE_TK);
  localparam logic [TK_W-1:0] POST_C   = TK_W'(POST_NOTCH_TK);
  localparam logic [TK_W-1:0] SMAX_C   = TK_W'(SEARCH_MAX_TK);
  localparam logic [TK_W-1:0] RAMP_C   = TK_W'(TX_RAMP_TK);
  localparam logic [TK_W-1:0] CWAIT_C  = TK_W'(CAL_WAIT_TK);
  localparam logic [TK_W-1:0] ONE_C    = 10'h001;

  function automatic logic [31:0] wb_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic rx_gain_t rx_split(input logic [6:0] g);
    rx_gain_t   s;
    logic [6:0] r;
    s.lna = (g >= LNA_ON_DB);
    r = s.lna ? g - LNA_DB : g;
    if (r >= 7'(2 * FILT_STEP_DB)) begin
      s.filt = 2'h2;
    end else if (r >= FILT_STEP_DB) begin
      s.filt = 2'h1;
    end else begin
      s.filt = 2'h0;
    end
    s.bb = 5'(r - 7'(s.filt) * FILT_STEP_DB);
    return s;
  endfunction

  function automatic logic signed [7:0] nudge(input logic signed [7:0] v,
                                              input logic down);
    return down ? v - 8'sh01 : v + 8'sh01;
  endfunction

  logic tick;

  ref_tick_gen u_tick (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .tick_o (tick)
  );

  // Register bus
  logic [7:0]  ctrl_q;
  logic [6:0]  maxg_q;
  logic [23:0] wait_q;
  logic [3:0]  txg_q;
  logic [7:0]  txdly_q;
  logic        wr_en;
  logic        cal_go;
  logic        restart;
  logic [31:0] rd_d;
  logic [31:0] ctrl_w;

  assign wr_en  = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
  assign ctrl_w = wb_merge({24'h000000, ctrl_q}, wb_dat_i, wb_sel_i);
  // Go and restart are pulses, never stored
  assign cal_go  = wr_en && wb_adr_i == ADR_CTRL && ctrl_w[CTRL_CAL_GO];
  assign restart = wr_en && wb_adr_i == ADR_CTRL && ctrl_w[CTRL_RESTART];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q       <= CTRL_RST;
      maxg_q       <= MAXG_RST;
      wait_q       <= WAIT_RST;
      txg_q        <= TXG_RST;
      txdly_q      <= TXDLY_RST;
      synth_code_o <= SYNTH_RST;
    end else if (wr_en) begin
      if (wb_adr_i == ADR_CTRL) begin
        ctrl_q <= {3'h0, 2'h0, ctrl_w[2:0]};
      end else if (wb_adr_i == ADR_MAXG) begin
        maxg_q <= 7'(wb_merge({25'h0, maxg_q}, wb_dat_i, wb_sel_i));
      end else if (wb_adr_i == ADR_WAIT) begin
        wait_q <= 24'(wb_merge({8'h00, wait_q}, wb_dat_i, wb_sel_i));
      end else if (wb_adr_i == ADR_TXCFG) begin
        {txdly_q, txg_q} <= 12'(wb_merge({20'h0, txdly_q, txg_q},
                                         wb_dat_i, wb_sel_i));
      end else if (wb_adr_i == ADR_SYNTH) begin
        // Each code step is one 0.5 MHz oscillator increment
        synth_code_o <= 8'(wb_merge({24'h0, synth_code_o},
                                    wb_dat_i, wb_sel_i));
      end
    end
  end

  // Receive gain loop
  agc_state_t      agc_q;
  logic [6:0]      gain_q;
  logic [TK_W-1:0] agc_cnt_q;
  logic [TK_W-1:0] srch_cnt_q;
  logic [1:0]      cyc_left_q;
  logic            rx_prev_q;
  logic            rx_new;
  logic [6:0]      step;
  logic [6:0]      gain_nx;
  logic [7:0]      wait_sel;
  logic            search_end;
  rx_gain_t        g_now;
  rx_gain_t        g_nx;
  notch_t          notch_d;

  assign rx_new = (rx_mode_i & ~rx_prev_q) | burst_start_i | restart;
  // Positive error means output above nominal; clamp so gain stays >= 0
  assign step = (rssi_err_i > $signed({1'b0, gain_q})) ? gain_q
                                                       : rssi_err_i[6:0];
  assign gain_nx = gain_q - step;
  assign g_now   = rx_split(gain_q);
  assign g_nx    = rx_split(gain_nx);
  assign search_end = rssi_err_i <= 8'sh00 || gain_q == 7'h00 ||
                      srch_cnt_q >= SMAX_C;

  // Wait after the switch depends on the coarsest stage that moved
  always_comb begin
    if (g_now.lna != g_nx.lna) begin
      wait_sel = wait_q[7:0];
    end else if (g_now.filt != g_nx.filt) begin
      wait_sel = wait_q[15:8];
    end else begin
      wait_sel = wait_q[23:16];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_prev_q <= 1'b0;
    end else begin
      rx_prev_q <= rx_mode_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      agc_q      <= AGC_IDLE;
      gain_q     <= 7'h00;
      agc_cnt_q  <= 10'h000;
      srch_cnt_q <= 10'h000;
      cyc_left_q <= 2'h0;
    end else if (!rx_mode_i) begin
      agc_q <= AGC_IDLE;
    end else if (rx_new) begin
      agc_q      <= AGC_SETTLE;
      gain_q     <= maxg_q;
      agc_cnt_q  <= SETTLE_C;
      cyc_left_q <= ctrl_q[CTRL_DIV_EN] ?
                    ctrl_q[CTRL_CYC_LSB +: 2] : 2'h0;
    end else if (tick) begin
      case (agc_q)
        AGC_SETTLE: begin
          if (agc_cnt_q <= ONE_C) begin
            agc_q      <= AGC_DECIDE;
            srch_cnt_q <= 10'h000;
          end else begin
            agc_cnt_q <= agc_cnt_q - ONE_C;
          end
        end
        AGC_DECIDE: begin
          srch_cnt_q <= srch_cnt_q + ONE_C;
          if (search_end && cyc_left_q != 2'h0) begin
            cyc_left_q <= cyc_left_q - 2'h1;
            gain_q     <= maxg_q;
            agc_cnt_q  <= SETTLE_C;
            agc_q      <= AGC_SETTLE;
          end else if (search_end) begin
            agc_cnt_q <= POST_C;
            agc_q     <= AGC_POST;
          end else begin
            gain_q    <= gain_nx;
            agc_cnt_q <= {2'h0, wait_sel};
            agc_q     <= AGC_WAIT;
          end
        end
        AGC_WAIT: begin
          srch_cnt_q <= srch_cnt_q + ONE_C;
          if (agc_cnt_q <= ONE_C) begin
            agc_q <= AGC_DECIDE;
          end else begin
            agc_cnt_q <= agc_cnt_q - ONE_C;
          end
        end
        AGC_POST: begin
          if (agc_cnt_q <= ONE_C) begin
            agc_q <= AGC_HOLD;
          end else begin
            agc_cnt_q <= agc_cnt_q - ONE_C;
          end
        end
        default: agc_q <= agc_q;
      endcase
    end
  end

  always_comb begin
    case (agc_q)
      AGC_SETTLE: notch_d = NOTCH_1M;
      AGC_DECIDE: notch_d = NOTCH_1M;
      AGC_WAIT:   notch_d = (gain_q == maxg_q) ? NOTCH_1M
                                               : NOTCH_10M;
      AGC_POST:   notch_d = NOTCH_100K;
      default:    notch_d = NOTCH_10K;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      notch_sel_o <= NOTCH_10K;
      rx_gain_o   <= '0;
      agc_done_o  <= 1'b0;
    end else begin
      notch_sel_o <= notch_d;
      rx_gain_o   <= g_now;
      agc_done_o  <= (agc_q == AGC_POST) || (agc_q == AGC_HOLD);
    end
  end

  // Transmit ramp sequencing
  tx_state_t       tx_q;
  logic [TK_W-1:0] tx_cnt_q;
  logic            tx_prev_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_q      <= TX_IDLE;
      tx_cnt_q  <= 10'h000;
      tx_prev_q <= 1'b0;
    end else begin
      tx_prev_q <= tx_mode_i;
      if (!tx_mode_i) begin
        tx_q <= TX_IDLE;
      end else if (!tx_prev_q) begin
        tx_q     <= TX_DELAY;
        tx_cnt_q <= {2'h0, txdly_q};
      end else if (tick) begin
        case (tx_q)
          TX_DELAY: begin
            if (tx_cnt_q <= ONE_C) begin
              tx_q     <= TX_RAMP;
              tx_cnt_q <= RAMP_C;
            end else begin
              tx_cnt_q <= tx_cnt_q - ONE_C;
            end
          end
          TX_RAMP: begin
            if (tx_cnt_q <= ONE_C) begin
              tx_q <= TX_ON;
            end else begin
              tx_cnt_q <= tx_cnt_q - ONE_C;
            end
          end
          default: tx_q <= tx_q;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_ramp_o <= 1'b0;
      tx_on_o   <= 1'b0;
      tx_gain_o <= '0;
      fir_i_o   <= 1'b0;
      fir_q_o   <= 1'b0;
    end else begin
      tx_ramp_o <= (tx_q == TX_RAMP);
      tx_on_o   <= (tx_q == TX_ON);
      // 8 dB upconverter step plus 0-7 dB filter: 15 dB in 1 dB steps
      tx_gain_o <= {txg_q[3], txg_q[2:0]};
      if (tick) begin
        fir_i_o <= tx_i_bit_i;
        fir_q_o <= tx_q_bit_i;
      end
    end
  end

  // Carrier-leakage calibration: per-axis descent on measured leakage.
  // Limitation: no saturation guard, a runaway axis wraps between +127 and -128.
  cal_state_t         cal_st_q;
  logic [TK_W-1:0]    cal_cnt_q;
  logic [7:0]         best_q;
  logic               axis_q;
  logic               down_q;
  logic               first_q;
  logic               base_q;
  logic signed [7:0]  cur;
  logic signed [7:0]  cur_nx;

  assign cur = axis_q ? cal_q_o : cal_i_o;

  always_comb begin
    if (base_q || lo_leak_i < best_q) begin
      cur_nx = nudge(cur, down_q);
    end else if (first_q && !down_q) begin
      cur_nx = cur - 8'sh02;
    end else begin
      cur_nx = nudge(cur, !down_q);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cal_st_q  <= CAL_IDLE;
      cal_cnt_q <= 10'h000;
      best_q    <= 8'hFF;
      axis_q    <= 1'b0;
      down_q    <= 1'b0;
      first_q   <= 1'b1;
      base_q    <= 1'b1;
      cal_i_o   <= 8'sh00;
      cal_q_o   <= 8'sh00;
    end else if (cal_go) begin
      cal_st_q  <= CAL_MEAS;
      cal_cnt_q <= CWAIT_C;
      axis_q    <= 1'b0;
      down_q    <= 1'b0;
      first_q   <= 1'b1;
      base_q    <= 1'b1;
    end else if (tick && cal_st_q == CAL_MEAS) begin
      if (cal_cnt_q > ONE_C) begin
        cal_cnt_q <= cal_cnt_q - ONE_C;
      end else begin
        cal_cnt_q <= CWAIT_C;
        if (axis_q) begin
          cal_q_o <= cur_nx;
        end else begin
          cal_i_o <= cur_nx;
        end
        if (base_q || lo_leak_i < best_q) begin
          best_q  <= lo_leak_i;
          first_q <= base_q;
          base_q  <= 1'b0;
        end else if (first_q && !down_q) begin
          down_q <= 1'b1;
        end else begin
          down_q  <= 1'b0;
          first_q <= 1'b1;
          base_q  <= 1'b1;
          axis_q  <= 1'b1;
          if (axis_q) begin
            cal_st_q <= CAL_DONE;
          end
        end
      end
    end
  end

  // Register read path
  always_comb begin
    if (wb_adr_i == ADR_CTRL) begin
      rd_d = {24'h000000, ctrl_q};
    end else if (wb_adr_i == ADR_MAXG) begin
      rd_d = {25'h0000000, maxg_q};
    end else if (wb_adr_i == ADR_WAIT) begin
      rd_d = {8'h00, wait_q};
    end else if (wb_adr_i == ADR_TXCFG) begin
      rd_d = {20'h00000, txdly_q, txg_q};
    end else if (wb_adr_i == ADR_SYNTH) begin
      rd_d = {24'h000000, synth_code_o};
    end else if (wb_adr_i == ADR_STAT) begin
      rd_d = 32'h00000000;
      rd_d[ST_NOTCH_LSB +: 2] = notch_sel_o;
      rd_d[ST_AGC_LSB +: 3]   = agc_q;
      rd_d[ST_TX_LSB +: 2]    = tx_q;
      rd_d[ST_CAL_LSB +: 2]   = cal_st_q;
      rd_d[ST_GAIN_LSB +: 7]  = gain_q;
    end else if (wb_adr_i == ADR_CAL) begin
      rd_d = {16'h0000, cal_q_o, cal_i_o};
    end else begin
      rd_d = 32'h00000000;
    end
  end

  // Unmapped addresses are acked with zero data so a master never hangs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      wb_dat_o <= rd_d;
    end
  end

endmodule

// >>> tb/rx_front_model.sv
// Receiver level meter and leakage meter facing the sequencer
`timescale 1ns/1ps
module rx_front_model (
  input  wire logic                    clk_i,
  input  wire radio_seq_pkg::rx_gain_t gain_i,
  input  wire logic [6:0]              want_i,
  input  wire logic signed [7:0]       cal_i_i,
  input  wire logic signed [7:0]       cal_q_i,
  output logic signed [7:0]            err_o,
  output logic [7:0]                   leak_o
);
  import radio_seq_pkg::*;
  localparam logic signed [7:0] BEST_I = 8'sh03;
  localparam logic signed [7:0] BEST_Q = 8'shFE;
  function automatic logic [7:0] mag(input logic signed [7:0] v);
    return (v < 0) ? -v : v;
  endfunction
  // Registered, so every decision sees one clock of meter lag
  always_ff @(posedge clk_i) begin
    err_o <= 8'(gain_i.lna * 8'h1E + gain_i.filt * 8'h0F
             + gain_i.bb - want_i);
    leak_o <= mag(cal_i_i - BEST_I) + mag(cal_q_i - BEST_Q);
  end
endmodule

// >>> tb/radio_seq_props.sv
// Port checks of the radio sequencer
`timescale 1ns/1ps
module radio_seq_props (
  input wire logic                  clk_i,
  input wire logic                  rst_i,
  input wire logic                  wb_cyc_i,
  input wire logic                  wb_stb_i,
  input wire logic                  wb_ack_o,
  input wire logic                  rx_mode_i,
  input wire logic                  burst_start_i,
  input wire radio_seq_pkg::notch_t notch_sel_o,
  input wire logic                  agc_done_o,
  input wire logic                  tx_ramp_o,
  input wire logic                  tx_on_o
);
  import radio_seq_pkg::*;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  logic [8:0] hp_q;
  logic [7:0] rmp_q;
  // Run lengths, so fixed intervals are measured rather than assumed
  always_ff @(posedge clk_i) begin
    if (notch_sel_o == NOTCH_100K)
      hp_q <= hp_q + 9'h001;
    else
      hp_q <= 9'h000;
  end
  always_ff @(posedge clk_i) begin
    if (tx_ramp_o)
      rmp_q <= rmp_q + 8'h01;
    else
      rmp_q <= 8'h00;
  end
  chk_ack_one_cycle: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer not one cycle");
  chk_rx_entry_notch: assert property (
    $rose(rx_mode_i) || rx_mode_i && burst_start_i
    |-> ##[1:2] notch_sel_o == NOTCH_1M)
    else $error("no 1 MHz corner on receive entry");
  chk_settle_corner: assert property (
    rx_mode_i && $past(rx_mode_i, 2) && !agc_done_o
    |-> notch_sel_o inside {NOTCH_10M, NOTCH_1M})
    else $error("wrong corner while settling");
  chk_done_corner: assert property (
    agc_done_o |-> notch_sel_o inside {NOTCH_100K, NOTCH_10K})
    else $error("wrong corner after settling");
  chk_post_length: assert property (
    $fell(notch_sel_o == NOTCH_100K) && agc_done_o
    |-> hp_q >= 9'h0F8 && hp_q <= 9'h0FC)
    else $error("100 kHz interval wrong length");
  // Any burst or bus access may start a new cycle, so both are excluded
  chk_hold_final: assert property (
    notch_sel_o == NOTCH_10K && agc_done_o && rx_mode_i
    && !burst_start_i && !$past(burst_start_i) && !wb_cyc_i
    && !$past(wb_cyc_i) && !$past(wb_cyc_i, 2)
    |=> notch_sel_o == NOTCH_10K)
    else $error("final corner not held");
  chk_ramp_length: assert property (
    $fell(tx_ramp_o) && tx_on_o |-> rmp_q >= 8'h62 && rmp_q <= 8'h66)
    else $error("ramp length wrong");
  chk_on_after_ramp: assert property (
    $rose(tx_on_o) |-> $past(tx_ramp_o))
    else $error("transmit on without ramp");
  cover property ($rose(agc_done_o));
  cover property ($rose(tx_on_o));
  cover property (rx_mode_i && burst_start_i);
endmodule
bind radio_seq radio_seq_props chk_u (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .rx_mode_i(rx_mode_i),
  .burst_start_i(burst_start_i), .notch_sel_o(notch_sel_o),
  .agc_done_o(agc_done_o), .tx_ramp_o(tx_ramp_o), .tx_on_o(tx_on_o));

// >>> tb/radio_gain_dc_notch_sequencer_bench.sv
// Self-checking bench for the radio sequencer
`timescale 1ns/1ps
module radio_gain_dc_notch_sequencer_bench;
  import radio_seq_pkg::*;
  logic              clk_i = 1'b0;
  logic              rst_i = 1'b1;
  logic              cyc, stb, we, rxm, txm, brst, ib, qb;
  logic              ack, done, ramp, on, fi, fq;
  logic [7:0]        adr, synth, leak;
  logic [3:0]        sel;
  logic [31:0]       wdat, dout, rdat;
  logic [6:0]        want;
  logic signed [7:0] err, ci, cq;
  notch_t            notch;
  rx_gain_t          rg;
  tx_gain_t          tg;
  logic [7:0]        dl [2] = '{8'h05, 8'h2C};
  int                errors = 0, samples_checked = 0, n, e;
  radio_seq dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel),
    .wb_dat_o(dout), .wb_ack_o(ack), .rx_mode_i(rxm), .tx_mode_i(txm),
    .burst_start_i(brst), .rssi_err_i(err), .lo_leak_i(leak),
    .tx_i_bit_i(ib), .tx_q_bit_i(qb), .notch_sel_o(notch),
    .rx_gain_o(rg), .agc_done_o(done), .synth_code_o(synth),
    .tx_gain_o(tg), .tx_ramp_o(ramp), .tx_on_o(on), .fir_i_o(fi),
    .fir_q_o(fq), .cal_i_o(ci), .cal_q_o(cq));
  rx_front_model far_u (
    .clk_i(clk_i), .gain_i(rg), .want_i(want), .cal_i_i(ci),
    .cal_q_i(cq), .err_o(err), .leak_o(leak));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    rdat = dout;
    cyc <= 1'b0;
    stb <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    wb(1'b0, a, 32'h0);
    check(rdat, x);
  endtask
  // Bounded wait on one status flag: 0 ramp, 1 on, 2 done
  task automatic wait_hi(input int w, input int lim);
    n = 0;
    while (((({done, on, ramp} >> w) & 3'h1) !== 3'h1) && n < lim) begin
      @(posedge clk_i);
      n++;
    end
  endtask
  function automatic logic [31:0] gdb(input rx_gain_t g);
    return 32'(g.lna) * 32'h1E + 32'(g.filt) * 32'h0F + 32'(g.bb);
  endfunction
  task automatic print_verdict();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial forever #10 clk_i = ~clk_i;
  initial begin
    repeat (20000) @(posedge clk_i);
    errors++;
    print_verdict();
  end
  initial begin
    {cyc, stb, we, rxm, txm, brst, ib, qb} <= 8'h00;
    adr <= 8'h00;
    sel <= 4'hF;
    wdat <= 32'h0;
    want <= 7'h32;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(ADR_MAXG, 32'h5A);
    rd(ADR_WAIT, 32'h161616);
    rd(ADR_TXCFG, 32'h2CF);
    rd(8'h1C, 32'h0);
    check(32'(tg), 32'hF);
    check(32'(notch), 32'(NOTCH_10K));
    wb(1'b1, ADR_SYNTH, 32'hA5);
    check(32'(synth), 32'hA5);
    for (int c = 0; c < 16; c++) begin
      wb(1'b1, ADR_TXCFG, 32'(c));
      check(32'(tg), 32'(c));
    end
    // Only lane 1 enabled: delay top nibble moves, gain code stays
    sel <= 4'h2;
    wb(1'b1, ADR_TXCFG, 32'hFFFFFF00);
    sel <= 4'hF;
    rd(ADR_TXCFG, 32'hF0F);
    foreach (dl[i]) begin
      wb(1'b1, ADR_TXCFG, {20'h0, dl[i], 4'h9});
      {ib, qb} <= {i[0], ~i[0]};
      txm <= 1'b1;
      e = int'(dl[i]) * 50 / 44;
      wait_hi(0, 400);
      check(32'(n >= e && n <= e + 4), 32'h1);
      check(32'({fi, fq}), 32'({i[0], ~i[0]}));
      wait_hi(1, 400);
      check(32'(n >= 97 && n <= 103), 32'h1);
      txm <= 1'b0;
      repeat (4) @(posedge clk_i);
      check(32'(on), 32'h0);
    end
    rxm <= 1'b1;
    repeat (3) @(posedge clk_i);
    check(32'(notch), 32'(NOTCH_1M));
    check(gdb(rg), 32'h5A);
    repeat (190) @(posedge clk_i);
    check(32'(notch), 32'(NOTCH_1M));
    wait_hi(2, 2000);
    check(32'(n <= 480), 32'h1);
    check(gdb(rg), 32'h32);
    repeat (300) @(posedge clk_i);
    check(32'(notch), 32'(NOTCH_10K));
    wb(1'b1, ADR_MAXG, 32'h46);
    wb(1'b1, ADR_CTRL, 32'h5);
    rxm <= 1'b0;
    repeat (4) @(posedge clk_i);
    rxm <= 1'b1;
    repeat (3) @(posedge clk_i);
    check(gdb(rg), 32'h46);
    wait_hi(2, 2000);
    check(32'(n >= 480), 32'h1);
    brst <= 1'b1;
    @(posedge clk_i);
    brst <= 1'b0;
    repeat (3) @(posedge clk_i);
    check(32'(done), 32'h0);
    wait_hi(2, 2000);
    check(32'(done), 32'h1);
    // Restart pulse also begins a new gain cycle; diversity now off
    wb(1'b1, ADR_CTRL, 32'h10);
    check(32'(done), 32'h0);
    check(32'(notch), 32'(NOTCH_1M));
    rxm <= 1'b0;
    wb(1'b1, ADR_CTRL, 32'hD);
    rd(ADR_CTRL, 32'h5);
    n = 0;
    do begin
      wb(1'b0, ADR_STAT, 32'h0);
      n++;
    end while (rdat[8:7] !== 2'b10 && n < 1000);
    check(32'({cq, ci}), 32'hFE03);
    rd(ADR_CAL, 32'hFE03);
    print_verdict();
  end
endmodule
